/* evic_core.sv */
// Purpose: memory-mapped eight-level interrupt controller with
//          long-branch vector response.
// Assumes: all pins are asynchronous to SYS_CLK_I and far slower.
// Notes:   request lines are active low and latched on falling edges.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - five 8-bit registers: page, control, mask written; status, poll read.
// - page register gives vector bits 15..8, same for every source.
// - control bits 7..4 give low vector bits, fewer as interval grows.
// - unprogrammed low vector bits hold the serviced request number and zeros.
// - request number 0..7 sits just below programmed bits, zeros below.
// - control low nibble: master interrupt, master mask, interval select.
// - mask bit n set masks request n; chain input is never masked.
// - status bit n shows pending request n, masked or not.
// - poll read returns low vector byte of current request.
// - vector fetch answers three bytes on consecutive fetch cycles.
// - bytes are long-branch opcode, page register, low vector byte.
// - only programmed bits among 4..7 are copied from control.
// - line 7 has highest priority, line 0 lowest.
// - read with x=1,y=0 returns branch and vector of the winner.
// - reads 00 status, 01 poll; writes 10 page, 01 control, 00 mask.
module evic_core
  import evic_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [evic_pkg::NUM_REQ-1:0] REQ_N_I,
  input wire logic CHAIN_PRIORITY_IN_I,
  input wire logic TIMING_PULSE_FIRST_I,
  input wire logic TIMING_PULSE_SECOND_I,
  input wire logic MEM_READ_STROBE_N_I,
  input wire logic MEM_WRITE_STROBE_N_I,
  input wire logic CS_I,
  input wire logic CS_N_I,
  input wire logic CS_X_I,
  input wire logic CS_Y_I,
  input wire logic [evic_pkg::DATA_W-1:0] DATA_LINES_I,
  output logic [evic_pkg::DATA_W-1:0] DATA_LINES_O,
  output logic DATA_LINES_OE_N_O,
  output logic IRQ_N_O
);
  import evic_pkg::*;

  // synchronised pins
  evic_bus_s bus_raw;
  evic_bus_s bus;
  logic [NUM_REQ-1:0] req_n_s;
  logic [DATA_W-1:0] data_s;
  logic chain_s;

  // edge detection on synced signals
  logic tpa_d_r;
  logic tpb_d_r;
  logic [NUM_REQ-1:0] req_n_d_r;
  logic tpa_fall;
  logic tpb_fall;
  logic [NUM_REQ-1:0] req_fall;

  // registers
  logic [7:0] page_r;
  logic [7:0] control_r;
  logic [7:0] mask_r;
  logic [NUM_REQ-1:0] pending_r;

  // bus cycle state
  logic selected_r;
  logic [1:0] vec_idx_r;
  logic [2:0] svc_num_r;

  // combinational
  logic [NUM_REQ-1:0] active;
  logic any_active;
  logic [2:0] win_num;
  logic [7:0] poll_byte;
  logic [7:0] svc_byte;
  logic [1:0] addr;
  logic unused_sel;
  logic read_act;
  logic write_act;
  logic fetch_ok;
  logic fetch_take;
  logic drive_nxt;
  logic [7:0] data_nxt;
  logic [NUM_REQ-1:0] clr_req;

  assign bus_raw = '{TIMING_PULSE_FIRST_I, TIMING_PULSE_SECOND_I,
                     MEM_READ_STROBE_N_I, MEM_WRITE_STROBE_N_I,
                     CS_I, CS_N_I, CS_X_I, CS_Y_I};

  evic_sync #(
    .WIDTH(BUS_W),
    .RST_VAL(BUS_IDLE)
  ) u_sync_bus (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .d_i(bus_raw),
    .q_o(bus)
  );

  // request lines idle high, so reset to ones avoids a false edge
  evic_sync #(
    .WIDTH(NUM_REQ + 1),
    .RST_VAL({(NUM_REQ + 1){1'b1}})
  ) u_sync_req (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .d_i({CHAIN_PRIORITY_IN_I, REQ_N_I}),
    .q_o({chain_s, req_n_s})
  );

  // write data only used at the trailing edge of the second pulse, still synced for safety
  evic_sync #(
    .WIDTH(DATA_W),
    .RST_VAL('0)
  ) u_sync_data (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .d_i(DATA_LINES_I),
    .q_o(data_s)
  );

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tpa_d_r <= 1'b0;
      tpb_d_r <= 1'b0;
      req_n_d_r <= '1;
    end else begin
      tpa_d_r <= bus.timing_pulse_first;
      tpb_d_r <= bus.timing_pulse_second;
      req_n_d_r <= req_n_s;
    end
  end

  assign tpa_fall = tpa_d_r & ~bus.timing_pulse_first;
  assign tpb_fall = tpb_d_r & ~bus.timing_pulse_second;
  assign req_fall = req_n_d_r & ~req_n_s;

  // chip selects caught at trailing edge of first pulse
  // selection holds to the next first pulse, so select lines may
  // change freely once the pulse is over
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      selected_r <= 1'b0;
    end else if (tpa_fall) begin
      selected_r <= bus.cs & ~bus.cs_n & bus.sel_x & bus.sel_y;
    end
  end

  // priority and vector composition
  assign active = pending_r & ~mask_r;

  always_comb begin
    win_num = 3'h0;
    // ascending scan lets the highest line overwrite
    for (int i = 0; i < NUM_REQ; i++) begin
      if (active[i]) begin
        win_num = 3'(i);
      end
    end
  end

  assign any_active = |active;

  function automatic logic [7:0] low_vector(input logic [7:0] ctl,
                                            input logic [2:0] num);
    logic [3:0] prog;
    logic [7:0] res;
    prog = ctl[CTL_LOW_ADDR_MSB:CTL_LOW_ADDR_LSB];
    res = 8'h00;
    unique case (ctl[CTL_INTERVAL_MSB:CTL_INTERVAL_LSB])
      INTERVAL_2: begin
        res = {prog[3:0], num, 1'b0};
      end
      INTERVAL_4: begin
        res = {prog[3:1], num, 2'h0};
      end
      INTERVAL_8: begin
        res = {prog[3:2], num, 3'h0};
      end
      INTERVAL_16: begin
        res = {prog[3], num, 4'h0};
      end
    endcase
    // dropped control bits never reach the byte
    return res;
  endfunction

  assign poll_byte = low_vector(control_r, win_num);
  assign svc_byte = low_vector(control_r, svc_num_r);

  // access decode; address valid from the second pulse onward
  assign addr = {bus.sel_x, bus.sel_y};
  assign unused_sel = (addr == SEL_UNUSED);
  assign read_act = selected_r & ~bus.rd_n & bus.wr_n & ~unused_sel;
  assign write_act = selected_r & ~bus.wr_n & bus.rd_n & ~unused_sel;

  // a lower controller stays silent while a higher one is asking
  assign fetch_ok = (vec_idx_r != 2'h0) | chain_s;
  assign fetch_take = read_act & (addr == SEL_VECTOR) & fetch_ok &
                      tpb_fall;

  // vector fetch sequencing
  // limitation: a fetch cut short by reset or another access restarts
  // at the opcode byte, so the cpu must fetch all three in a row
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      vec_idx_r <= 2'h0;
    end else if (fetch_take) begin
      if (vec_idx_r == VEC_BYTES_LAST) begin
        vec_idx_r <= 2'h0;
      end else begin
        vec_idx_r <= vec_idx_r + 2'h1;
      end
    end else if (tpb_fall & selected_r & ~unused_sel &
                 ~(read_act & (addr == SEL_VECTOR))) begin
      // any other selected access, except one with the unused select code, breaks a half-done fetch
      vec_idx_r <= 2'h0;
    end
  end

  // winner frozen at the opcode byte keeps the three bytes coherent
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      svc_num_r <= 3'h0;
    end else if (fetch_take & (vec_idx_r == 2'h0)) begin
      svc_num_r <= win_num;
    end
  end

  // serviced latch cleared at the opcode fetch
  always_comb begin
    clr_req = '0;
    if (fetch_take & (vec_idx_r == 2'h0) & any_active) begin
      clr_req[win_num] = 1'b1;
    end
  end

  // request latches; a new edge wins over a clear
  // a status read leaves latches alone; only a vector fetch services
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pending_r <= '0;
    end else if (~control_r[CTL_MASTER_IRQ_BIT]) begin
      // master interrupt reset clears latches, a new edge shows for one clock only
      pending_r <= req_fall;
    end else begin
      pending_r <= (pending_r & ~clr_req) | req_fall;
    end
  end

  // register writes at the trailing edge of the second pulse
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      page_r <= PAGE_RST;
    end else if (write_act & tpb_fall & (addr == SEL_PAGE)) begin
      page_r <= data_s;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      control_r <= CONTROL_RST;
    end else if (write_act & tpb_fall & (addr == SEL_CONTROL)) begin
      control_r <= data_s;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mask_r <= MASK_RST;
    end else if (write_act & tpb_fall & (addr == SEL_MASK)) begin
      mask_r <= data_s;
    end else if (write_act & tpb_fall & (addr == SEL_CONTROL) &
                 ~data_s[CTL_MASTER_MASK_BIT]) begin
      // master mask reset unmasks every line
      mask_r <= MASK_RST;
    end
  end

  // read data path; page, control and mask have no read-back
  always_comb begin
    drive_nxt = 1'b0;
    data_nxt = 8'h00;
    if (read_act) begin
      unique case (addr)
        SEL_VECTOR: begin
          if (fetch_ok) begin
            drive_nxt = 1'b1;
            unique case (vec_idx_r)
              2'h0: data_nxt = LONG_BRANCH_OP;
              2'h1: data_nxt = page_r;
              default: data_nxt = svc_byte;
            endcase
          end
        end
        SEL_POLL: begin
          drive_nxt = 1'b1;
          data_nxt = poll_byte;
        end
        SEL_STATUS: begin
          drive_nxt = 1'b1;
          data_nxt = pending_r;
        end
        default: begin
          drive_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DATA_LINES_O <= 8'h00;
      DATA_LINES_OE_N_O <= 1'b1;
    end else begin
      DATA_LINES_O <= data_nxt;
      DATA_LINES_OE_N_O <= ~drive_nxt;
    end
  end

  // interrupt output; chain input gates but is never masked
  // chain input passes the synchroniser too, so a higher controller
  // silences this one within three clocks rather than at once
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      IRQ_N_O <= 1'b1;
    end else begin
      IRQ_N_O <= ~(any_active & chain_s &
                   control_r[CTL_MASTER_IRQ_BIT]);
    end
  end

endmodule // evic_core
`default_nettype wire

/* evic_core_checker.sv */
// Purpose: port-level checks of the interrupt controller.
// Assumes: bound to evic_core; one clock domain.
// Notes: margins cover 2 sync flops, decode and the output flop.
`timescale 1ns/1ns
`default_nettype none
module evic_core_checker (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic CHAIN_PRIORITY_IN_I,
  input wire logic TIMING_PULSE_SECOND_I,
  input wire logic MEM_READ_STROBE_N_I,
  input wire logic MEM_WRITE_STROBE_N_I,
  input wire logic CS_X_I,
  input wire logic CS_Y_I,
  input wire logic [evic_pkg::DATA_W-1:0] DATA_LINES_O,
  input wire logic DATA_LINES_OE_N_O,
  input wire logic IRQ_N_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_wr_only;
    (!MEM_WRITE_STROBE_N_I && MEM_READ_STROBE_N_I) [*6];
  endsequence
  sequence s_idle;
    MEM_READ_STROBE_N_I [*6];
  endsequence
  sequence s_rd_phase;
    (TIMING_PULSE_SECOND_I && !MEM_READ_STROBE_N_I) [*5];
  endsequence
  a_reset_quiet: assert property ($fell(RST_I) |-> DATA_LINES_OE_N_O && IRQ_N_O)
    else $error("outputs active right after reset");
  a_drive_cause: assert property ($fell(DATA_LINES_OE_N_O) |-> $past(!MEM_READ_STROBE_N_I, 3))
    else $error("bus driven without a read strobe");
  a_write_quiet: assert property (s_wr_only |-> DATA_LINES_OE_N_O)
    else $error("bus driven during a write");
  a_release_bus: assert property (s_idle |-> DATA_LINES_OE_N_O)
    else $error("bus still driven after the strobe ended");
  a_unused_sel: assert property ((CS_X_I && CS_Y_I && !MEM_READ_STROBE_N_I) [*5] |-> DATA_LINES_OE_N_O)
    else $error("bus driven for the unused select code");
  a_chain_block: assert property ((!CHAIN_PRIORITY_IN_I) [*5] |-> IRQ_N_O)
    else $error("interrupt raised while chain input low");
  a_data_steady: assert property (s_rd_phase |-> $stable(DATA_LINES_O))
    else $error("read data changed within a fetch");
  a_oe_settle: assert property ($rose(DATA_LINES_OE_N_O) |-> $past(MEM_READ_STROBE_N_I, 3) || $past(CS_X_I && CS_Y_I, 3))
    else $error("bus released while the read still stood");
endmodule // evic_core_checker
bind evic_core evic_core_checker chk_i (
  .SYS_CLK_I(SYS_CLK_I),
  .RST_I(RST_I),
  .CHAIN_PRIORITY_IN_I(CHAIN_PRIORITY_IN_I),
  .TIMING_PULSE_SECOND_I(TIMING_PULSE_SECOND_I),
  .MEM_READ_STROBE_N_I(MEM_READ_STROBE_N_I),
  .MEM_WRITE_STROBE_N_I(MEM_WRITE_STROBE_N_I),
  .CS_X_I(CS_X_I),
  .CS_Y_I(CS_Y_I),
  .DATA_LINES_O(DATA_LINES_O),
  .DATA_LINES_OE_N_O(DATA_LINES_OE_N_O),
  .IRQ_N_O(IRQ_N_O)
);
`default_nettype wire

/* evic_cpu_model.sv */
// Purpose: cpu bus model driving the controller's pins.
// Assumes: shares the device clock; one access per call.
// Notes: idle data lines show the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none
module evic_cpu_model (
  input wire logic clk_i,
  input wire logic [7:0] rd_i,
  input wire logic oe_n_i,
  output logic tpa_o,
  output logic tpb_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic cs_o,
  output logic cs_n_o,
  output logic x_o,
  output logic y_o,
  output logic [7:0] data_o
);
  initial begin
    // both timing pulses idle low, strobes and low select idle high
    {tpa_o, tpb_o, rd_n_o, wr_n_o, cs_o, cs_n_o} = 6'h0d;
    {x_o, y_o} = 2'h0;
    data_o = 8'h00;
  end
  task automatic cyc(input logic sel, input logic rd, input logic [1:0] xy,
                     input logic [7:0] wd, output logic [7:0] q,
                     output logic oe);
    @(posedge clk_i);
    tpa_o <= 1'b1;
    cs_o <= sel;
    cs_n_o <= !sel;
    {x_o, y_o} <= 2'h3;
    repeat (10) @(posedge clk_i);
    tpa_o <= 1'b0;
    repeat (10) @(posedge clk_i);
    {x_o, y_o} <= xy;
    rd_n_o <= !rd;
    wr_n_o <= rd;
    data_o <= rd ? ~data_o : wd;
    repeat (4) @(posedge clk_i);
    tpb_o <= 1'b1;
    repeat (9) @(posedge clk_i);
    // sample away from the edge so device updates have landed
    @(negedge clk_i);
    q = rd_i;
    oe = oe_n_i;
    @(posedge clk_i);
    tpb_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    cs_o <= 1'b0;
    cs_n_o <= 1'b1;
    {x_o, y_o} <= 2'h0;
    data_o <= ~data_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // evic_cpu_model
`default_nettype wire

/* evic_pkg.sv */
// Purpose: shared constants and types of the eight-level vectoring
//          interrupt controller.
// Assumes: 8-bit data bus, register select coded on the two select pins.
// Notes:   register codes are the {x,y} values seen during the second
//          timing pulse.
package evic_pkg;

  localparam int NUM_REQ = 8;
  localparam int DATA_W = 8;
  localparam int SYNC_STAGES = 2;

  // {x,y} register select codes
  localparam logic [1:0] SEL_VECTOR = 2'h2;
  localparam logic [1:0] SEL_PAGE = 2'h2;
  localparam logic [1:0] SEL_CONTROL = 2'h1;
  localparam logic [1:0] SEL_POLL = 2'h1;
  localparam logic [1:0] SEL_MASK = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h0;
  localparam logic [1:0] SEL_UNUSED = 2'h3;

  // control register fields
  localparam int CTL_LOW_ADDR_MSB = 7;
  localparam int CTL_LOW_ADDR_LSB = 4;
  localparam int CTL_MASTER_IRQ_BIT = 3;
  localparam int CTL_MASTER_MASK_BIT = 2;
  localparam int CTL_INTERVAL_MSB = 1;
  localparam int CTL_INTERVAL_LSB = 0;

  // interval select codes
  localparam logic [1:0] INTERVAL_2 = 2'h0;
  localparam logic [1:0] INTERVAL_4 = 2'h1;
  localparam logic [1:0] INTERVAL_8 = 2'h2;
  localparam logic [1:0] INTERVAL_16 = 2'h3;

  localparam logic [7:0] LONG_BRANCH_OP = 8'hc0;
  localparam logic [1:0] VEC_BYTES_LAST = 2'h2;

  // reset values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  // bus control pins after synchronising
  typedef struct packed {
    logic timing_pulse_first;
    logic timing_pulse_second;
    logic rd_n;
    logic wr_n;
    logic cs;
    logic cs_n;
    logic sel_x;
    logic sel_y;
  } evic_bus_s;

  localparam int BUS_W = $bits(evic_bus_s);
  localparam evic_bus_s BUS_IDLE = '{1'b0, 1'b0, 1'b1, 1'b1,
                                     1'b0, 1'b1, 1'b0, 1'b0};

endpackage

/* evic_sync.sv */
// Purpose: two-flop synchroniser for a bundle of pin inputs.
// Assumes: each bit is an independent level from outside the clock.
// Notes:   reset value is a parameter so idle levels hold through reset.
`timescale 1ns/1ns
`default_nettype none
module evic_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule // evic_sync
`default_nettype wire

/* evic_tb.sv */
// Purpose: self-checking bench of the interrupt controller.
// Assumes: cpu model drives all bus pins.
// Notes: expected vector bytes are built here from the field layout.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import evic_pkg::*;
  logic SYS_CLK_I, RST_I, chain;
  logic [7:0] req_n, dout, q;
  wire logic timing_pulse_first, timing_pulse_second, rd_n, wr_n, cs, cs_n, x, y;
  wire logic [7:0] din;
  logic oe_n, irq_n, oe;
  int err_total, check_count;
  initial begin
    SYS_CLK_I = 1'b0;
    forever #2 SYS_CLK_I = ~SYS_CLK_I;
  end
  evic_core uut (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .REQ_N_I(req_n),
    .CHAIN_PRIORITY_IN_I(chain), .TIMING_PULSE_FIRST_I(timing_pulse_first),
    .TIMING_PULSE_SECOND_I(timing_pulse_second), .MEM_READ_STROBE_N_I(rd_n),
    .MEM_WRITE_STROBE_N_I(wr_n), .CS_I(cs), .CS_N_I(cs_n), .CS_X_I(x),
    .CS_Y_I(y), .DATA_LINES_I(din), .DATA_LINES_O(dout),
    .DATA_LINES_OE_N_O(oe_n), .IRQ_N_O(irq_n));
  evic_cpu_model cpu (.clk_i(SYS_CLK_I), .rd_i(dout), .oe_n_i(oe_n),
    .tpa_o(timing_pulse_first), .tpb_o(timing_pulse_second), .rd_n_o(rd_n), .wr_n_o(wr_n), .cs_o(cs),
    .cs_n_o(cs_n), .x_o(x), .y_o(y), .data_o(din));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] exp_low(input logic [3:0] nb,
                                         input logic [1:0] iv,
                                         input logic [2:0] n);
    case (iv)
      INTERVAL_2: return {nb, n, 1'b0};
      INTERVAL_4: return {nb[3:1], n, 2'h0};
      INTERVAL_8: return {nb[3:2], n, 3'h0};
      default: return {nb[3], n, 4'h0};
    endcase
  endfunction
  task automatic wr(input logic [1:0] xy, input logic [7:0] d);
    cpu.cyc(1'b1, 1'b0, xy, d, q, oe);
  endtask
  task automatic rchk(input logic [1:0] xy, input logic [7:0] e);
    cpu.cyc(1'b1, 1'b1, xy, 8'h00, q, oe);
    chk({7'h0, oe}, 8'h00);
    chk(q, e);
  endtask
  task automatic pulse(input int n);
    @(posedge SYS_CLK_I);
    req_n[n] <= 1'b0;
    repeat (4) @(posedge SYS_CLK_I);
    req_n[n] <= 1'b1;
    repeat (6) @(posedge SYS_CLK_I);
  endtask
  task automatic t_reset;
    chk({6'h0, oe_n, irq_n}, 8'h03);
  endtask
  task automatic t_vector;
    wr(SEL_MASK, 8'h00);
    wr(SEL_CONTROL, 8'hce);
    wr(SEL_PAGE, 8'h84);
    pulse(4);
    chk({7'h0, irq_n}, 8'h00);
    rchk(SEL_STATUS, 8'h10);
    rchk(SEL_POLL, 8'he0);
    rchk(SEL_VECTOR, LONG_BRANCH_OP);
    rchk(SEL_VECTOR, 8'h84);
    rchk(SEL_VECTOR, 8'he0);
    rchk(SEL_STATUS, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
  endtask
  task automatic t_intervals;
    pulse(6);
    pulse(2);
    for (int iv = 0; iv < 4; iv++) begin
      wr(SEL_CONTROL, {4'ha, 2'h3, iv[1:0]});
      rchk(SEL_POLL, exp_low(4'ha, iv[1:0], 3'h6));
    end
    wr(SEL_MASK, 8'h40);
    rchk(SEL_POLL, exp_low(4'ha, INTERVAL_16, 3'h2));
    rchk(SEL_STATUS, 8'h44);
  endtask
  task automatic t_refuse;
    cpu.cyc(1'b1, 1'b1, SEL_UNUSED, 8'h00, q, oe);
    chk({7'h0, oe}, 8'h01);
    cpu.cyc(1'b0, 1'b1, SEL_STATUS, 8'h00, q, oe);
    chk({7'h0, oe}, 8'h01);
    chk({7'h0, irq_n}, 8'h00);
    chain <= 1'b0;
    repeat (8) @(posedge SYS_CLK_I);
    chk({7'h0, irq_n}, 8'h01);
    chain <= 1'b1;
    repeat (8) @(posedge SYS_CLK_I);
    rchk(SEL_VECTOR, LONG_BRANCH_OP);
    rchk(SEL_VECTOR, 8'h84);
    rchk(SEL_VECTOR, exp_low(4'ha, INTERVAL_16, 3'h2));
  endtask
  task automatic t_master;
    wr(SEL_CONTROL, 8'haa);
    rchk(SEL_POLL, exp_low(4'ha, INTERVAL_8, 3'h6));
    chk({7'h0, irq_n}, 8'h00);
    wr(SEL_CONTROL, 8'ha2);
    rchk(SEL_STATUS, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
    pulse(5);
    rchk(SEL_STATUS, 8'h00);
  endtask
  task automatic t_midreset;
    RST_I <= 1'b1;
    repeat (8) @(posedge SYS_CLK_I);
    RST_I <= 1'b0;
    repeat (6) @(posedge SYS_CLK_I);
    chk({6'h0, oe_n, irq_n}, 8'h03);
    rchk(SEL_VECTOR, LONG_BRANCH_OP);
    rchk(SEL_VECTOR, PAGE_RST);
    rchk(SEL_VECTOR, exp_low(4'h0, INTERVAL_2, 3'h0));
  endtask
  initial begin
    #40000;
    err_total++;
    print_verdict;
  end
  initial begin
    err_total = 0;
    check_count = 0;
    RST_I = 1'b1;
    req_n = 8'hff;
    chain = 1'b1;
    repeat (8) @(posedge SYS_CLK_I);
    RST_I <= 1'b0;
    repeat (6) @(posedge SYS_CLK_I);
    t_reset;
    t_vector;
    t_intervals;
    t_refuse;
    t_master;
    t_midreset;
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
